/* tb/zol_loader_bench.sv */
// self-checking bench of the zoom oscillator loader
`timescale 1ns/1ps
`include "zol_consts.svh"

`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, (g), (e)); end end

module zol_loader_bench;
	import zol_pkg::*;
	logic clock, rst, reg_wr, reg_rd, armed, trig_event, sync_pin, mix_valid;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata;
	logic signed [15:0] mix_i, mix_q, zoom_i, zoom_q;
	logic [39:0] osc_phase, osc_freq, ef, ep; // ef, ep: expected working
	logic zoom_valid;
	logic [10:0] ec; // expected coarse staging
	logic [28:0] efn; // expected fine staging
	int mismatches, total_checks;

	zol_loader zol_loader_inst (.clock(clock), .rst(rst), .reg_addr(reg_addr),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .armed(armed), .trig_event(trig_event),
		.trigger_sync_line(sync_pin), .mix_valid(mix_valid), .mix_i(mix_i),
		.mix_q(mix_q), .osc_phase(osc_phase), .osc_freq(osc_freq),
		.zoom_valid(zoom_valid), .zoom_i(zoom_i), .zoom_q(zoom_q));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	// ****************
	// bus and model
	// ****************
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask : wr

	// read data is registered: settled just after the taking edge
	task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rdata, e)
	endtask : rd_chk

	// upper byte and gap bits set to ones, they must be dropped
	task automatic wr_stage();
		wr(`ZOL_OFS_COARSE_HIGH, {8'hff, ec[10:3]});
		wr(`ZOL_OFS_COARSE_LOW, {8'hff, ec[2:0], 5'h1f});
		wr(`ZOL_OFS_FINE_BYTE3, {8'hff, efn[28:21]});
		wr(`ZOL_OFS_FINE_BYTE2, {8'hff, efn[20:13]});
		wr(`ZOL_OFS_FINE_BYTE1, {8'hff, efn[12:5]});
		wr(`ZOL_OFS_FINE_BYTE0, {8'hff, efn[4:0], 3'h7});
	endtask : wr_stage

	task automatic chk_stage();
		rd_chk(`ZOL_OFS_COARSE_HIGH, {8'h00, ec[10:3]});
		rd_chk(`ZOL_OFS_COARSE_LOW, {8'h00, ec[2:0], 5'h00});
		rd_chk(`ZOL_OFS_FINE_BYTE3, {8'h00, efn[28:21]});
		rd_chk(`ZOL_OFS_FINE_BYTE2, {8'h00, efn[20:13]});
		rd_chk(`ZOL_OFS_FINE_BYTE1, {8'h00, efn[12:5]});
		rd_chk(`ZOL_OFS_FINE_BYTE0, {8'h00, efn[4:0], 3'h0});
	endtask : chk_stage

	// expected effect of one transfer code on staging and working words
	function automatic void model(input logic [3:0] k);
		logic [39:0] src;
		logic sc, sf;
		src = k[0] ? ep : ef;
		sc = k == 4'h1 || k == 4'h8 || k == 4'ha || k == 4'hb || k > 4'hd;
		sf = k == 4'h1 || k == 4'h9 || k > 4'hb;
		if (k > 4'h1 && k < 4'h8) begin
			ec = k[1] ? src[39:29] : ec;
			efn = k[2] ? src[28:0] : efn;
		end else if (k != 4'h0) begin
			if (k < 4'ha || !k[0])
				ef = {sc ? ec : ef[39:29], sf ? efn : ef[28:0]};
			if (k < 4'ha || k[0])
				ep = {sc ? ec : ep[39:29], sf ? efn : ep[28:0]};
		end
	endfunction : model

	task automatic fire_trig();
		@(posedge clock);
		armed <= 1'b1;
		trig_event <= 1'b1;
		@(posedge clock);
		armed <= 1'b0;
		trig_event <= 1'b0;
		#1;
	endtask : fire_trig

	// one sample through mixer path; phase steps by the frequency
	task automatic samp(input logic signed [15:0] x, input logic signed [15:0] y);
		@(posedge clock);
		mix_valid <= 1'b1;
		mix_i <= x;
		mix_q <= -x;
		@(posedge clock);
		mix_valid <= 1'b0;
		#1;
		ep = ep + ef;
		`CHK({zoom_valid, zoom_i, zoom_q}, {1'b1, y, -y})
		`CHK(osc_phase, ep)
	endtask : samp

	// ****************
	// scenarios
	// ****************
	task automatic test_reset();
		#1;
		ec = 11'h000;
		efn = 29'h0;
		ef = 40'h0;
		ep = `ZOL_INIT_PHASE;
		`CHK({osc_freq, osc_phase}, {ef, ep})
		chk_stage();
		rd_chk(`ZOL_OFS_CONTROL, 16'h0000);
		rd_chk(`ZOL_OFS_LOAD_STROBE, 16'h0000);
		rd_chk(8'h10, 16'h0000);
		$display("test_reset done");
	endtask : test_reset

	// every code, even ones by strobe and odd ones by armed trigger
	task automatic test_codes();
		logic [39:0] pf, pp;
		for (int k = 15; k >= 0; k--) begin
			ec = {k[3:0], 7'h35};
			efn = {k[3:0], 25'h1abcdef};
			wr_stage();
			wr(`ZOL_OFS_CONTROL, {12'h000, k[3:0]});
			pf = ef;
			pp = ep;
			model(k[3:0]);
			if (k[0]) begin
				fire_trig();
			end else begin
				wr(`ZOL_OFS_LOAD_STROBE, 16'ha5a5);
				`CHK({osc_freq, osc_phase}, {pf, pp})
				@(posedge clock);
				#1;
			end
			`CHK({osc_freq, osc_phase}, {ef, ep})
			chk_stage();
		end
		$display("test_codes done");
	endtask : test_codes

	// worked programming: 100 khz at a 10 mhz rate, then 90 degrees
	task automatic test_program();
		longint num;
		// 100000 hz times 2048, over 10000000 hz
		num = 64'h186a0 * 64'h800;
		ec = 11'(num / 64'h989680);
		efn = 29'(((num % 64'h989680) * 64'h1dcd6500) / 64'h989680);
		wr_stage();
		wr(`ZOL_OFS_CONTROL, 16'h000e);
		wr(`ZOL_OFS_LOAD_STROBE, 16'h0000);
		@(posedge clock);
		#1;
		ef = {ec, efn};
		`CHK(osc_freq, {11'h014, 29'he4e1c00})
		// 90 degrees over 360, times 2048; mixer samples stay off meanwhile
		num = 64'h5a * 64'h800;
		ec = 11'(num / 64'h168);
		efn = 29'(((num % 64'h168) * 64'h1dcd6500) / 64'h168);
		wr_stage();
		wr(`ZOL_OFS_CONTROL, 16'h000f);
		wr(`ZOL_OFS_LOAD_STROBE, 16'h0000);
		@(posedge clock);
		#1;
		ep = {ec, efn};
		`CHK(osc_phase, {11'h200, 29'h0})
		samp(16'sh0007, 16'sh0007);
		$display("test_program done");
	endtask : test_program

	// 1-2-1 on old state, clear and its self-clear, then bypass
	task automatic test_filter();
		wr(`ZOL_OFS_CONTROL, 16'h0010);
		samp(16'sh0182, 16'sh0064);
		wr(`ZOL_OFS_CONTROL, 16'h0050);
		fire_trig();
		samp(16'sh0064, 16'sh0019);
		samp(16'sh00c8, 16'sh0064);
		fire_trig();
		samp(16'sh012c, 16'sh00c8);
		wr(`ZOL_OFS_CONTROL, 16'h0000);
		samp(16'sh04d2, 16'sh04d2);
		$display("test_filter done");
	endtask : test_filter

	// sync pin low for a few cycles, then back high
	task automatic sync_fall();
		@(posedge clock);
		sync_pin <= 1'b0;
		repeat (6) @(posedge clock);
		sync_pin <= 1'b1;
		#1;
	endtask : sync_fall

	// sync fall ignored without the reset bit; with it the stage inits
	task automatic test_init();
		sync_fall();
		`CHK({osc_freq, osc_phase}, {ef, ep})
		wr(`ZOL_OFS_CONTROL, 16'h0090);
		sync_fall();
		ef = 40'h0;
		ep = `ZOL_INIT_PHASE;
		`CHK({osc_freq, osc_phase}, {ef, ep})
		samp(16'sh0028, 16'sh0028);
		wr(`ZOL_OFS_CONTROL, 16'h0010);
		samp(16'sh0000, 16'sh0014);
		$display("test_init done");
	endtask : test_init

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		{rst, reg_wr, reg_rd, armed, trig_event, mix_valid} = 6'h20;
		sync_pin = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		mix_i = 16'sd0;
		mix_q = 16'sd0;
		mismatches = 0;
		total_checks = 0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		test_reset();
		test_codes();
		test_program();
		test_filter();
		test_init();
		tally_and_finish();
	end

	// whole run needs under 600 cycles; the 10000-cycle limit is a hang
	initial begin
		#50000;
		mismatches++;
		tally_and_finish();
	end
endmodule : zol_loader_bench

/* tb/zol_loader_monitor.sv */
// port checker of the zoom oscillator loader, bound to its top
`timescale 1ns/1ps
`include "zol_consts.svh"

module zol_loader_checker (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port and trigger
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_rdata,
	input wire logic armed,
	input wire logic trig_event,
	// samples and oscillator
	input wire logic mix_valid,
	input wire logic [`ZOL_WORD_W-1:0] osc_phase,
	input wire logic [`ZOL_WORD_W-1:0] osc_freq,
	input wire logic zoom_valid
);
	// decoded causes of a copy
	wire logic strb = reg_wr && reg_addr == `ZOL_OFS_LOAD_STROBE;
	wire logic fire = armed && trig_event;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// write-only places read back as zero
	wo_read_a: assert property (reg_rd &&
		(reg_addr == `ZOL_OFS_CONTROL || reg_addr == `ZOL_OFS_LOAD_STROBE)
		|=> reg_rdata == 16'h0000) else $error("write-only read nonzero");
	upper_zero_a: assert property (reg_rd
		|=> reg_rdata[15:8] == 8'h00) else $error("upper read byte nonzero");
	coarse_gap_a: assert property (reg_rd &&
		reg_addr == `ZOL_OFS_COARSE_LOW |=> reg_rdata[4:0] == 5'h00)
		else $error("coarse low gap bits nonzero");
	fine_gap_a: assert property (reg_rd &&
		reg_addr == `ZOL_OFS_FINE_BYTE0 |=> reg_rdata[2:0] == 3'h0)
		else $error("fine low gap bits nonzero");
	// frequency moves only two edges after a strobe, one edge after a trigger, or to zero at init
	freq_cause_a: assert property ($changed(osc_freq) |->
		$past(strb, 2) || $past(fire) || osc_freq == 40'h0)
		else $error("frequency changed without cause");
	phase_step_a: assert property (mix_valid && !fire && !$past(strb)
		|=> osc_phase == $past(osc_phase) + $past(osc_freq)
		|| osc_phase == `ZOL_INIT_PHASE) else $error("phase step wrong");
	phase_hold_a: assert property (!mix_valid && !fire && !$past(strb)
		|=> $stable(osc_phase) || osc_phase == `ZOL_INIT_PHASE)
		else $error("phase moved without sample");
	zoom_pulse_a: assert property (mix_valid |=> zoom_valid)
		else $error("filter output missing");
	zoom_quiet_a: assert property (!mix_valid |=> !zoom_valid)
		else $error("filter output without sample");
endmodule : zol_loader_checker

bind zol_loader zol_loader_checker zol_loader_checker_inst (.clock(clock),
	.rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .armed(armed), .trig_event(trig_event),
	.mix_valid(mix_valid), .osc_phase(osc_phase), .osc_freq(osc_freq),
	.zoom_valid(zoom_valid));

/* verilog/zol_consts.svh */
// register offsets, field positions, reset values and widths of the loader
`ifndef ZOL_CONSTS_SVH
`define ZOL_CONSTS_SVH

// register byte addresses on the 16-bit register port
`define ZOL_OFS_COARSE_HIGH 8'h30
`define ZOL_OFS_COARSE_LOW 8'h32
`define ZOL_OFS_FINE_BYTE3 8'h34
`define ZOL_OFS_FINE_BYTE2 8'h36
`define ZOL_OFS_FINE_BYTE1 8'h38
`define ZOL_OFS_FINE_BYTE0 8'h3a
`define ZOL_OFS_CONTROL 8'h3c
`define ZOL_OFS_LOAD_STROBE 8'h3e

// control byte field positions
`define ZOL_CTL_SEL_MSB 3
`define ZOL_CTL_SEL_LSB 0
`define ZOL_CTL_FILT_EN 4
`define ZOL_CTL_FILT_CLR 6
`define ZOL_CTL_RESET 7

// widths of the staging and working words and of the samples
`define ZOL_COARSE_W 11
`define ZOL_FINE_W 29
`define ZOL_WORD_W 40
`define ZOL_SAMP_W 16

// reset values
`define ZOL_CTL_RESET_VAL 8'h00
`define ZOL_FREQ_RESET_VAL 40'h00_0000_0000
`define ZOL_INIT_PHASE 40'h26_f369_d5c3

`endif

/* verilog/zol_loader.sv */
// zoom oscillator loader: staging registers, transfers, control and init
//
// Overview of operation
// - four-bit select picks the copy at trigger
// - store codes copy staging into working registers
// - codes 2 to 7 copy working back to staging
// - filter bit routes mixer output through lowpass
// - clear bit zeroes filter, self-clears at trigger
// - reset bit: sync fall initializes zoom stage
// - strobe write ignores data, starts selected copy
// - strobe copy lands on next clock cycle
// - armed trigger also performs the selected copy
// - coarse staging split over two byte registers
// - fine staging split over four byte registers
// - low coarse and fine bits sit high
// - phase accumulates frequency every sample
// - write-only control byte at 3ch
// - 16-bit cycles, upper byte ignored, gaps zero
`timescale 1ns/1ps
`include "zol_consts.svh"

module zol_loader (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// 16-bit register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata,
	// trigger side
	input wire logic armed,
	input wire logic trig_event,
	input wire logic trigger_sync_line,
	// complex mixer output
	input wire logic mix_valid,
	input wire logic signed [`ZOL_SAMP_W-1:0] mix_i,
	input wire logic signed [`ZOL_SAMP_W-1:0] mix_q,
	// oscillator and filtered output
	output logic [`ZOL_WORD_W-1:0] osc_phase,
	output logic [`ZOL_WORD_W-1:0] osc_freq,
	output logic zoom_valid,
	output logic signed [`ZOL_SAMP_W-1:0] zoom_i,
	output logic signed [`ZOL_SAMP_W-1:0] zoom_q
);
	import zol_pkg::*;

	// ***********************************************************
	// declarations
	// ***********************************************************

	logic [`ZOL_COARSE_W-1:0] coarse_ff; // coarse staging
	logic [`ZOL_FINE_W-1:0] fine_ff; // fine staging
	logic [7:0] ctl_ff; // control byte
	logic strobe_ff; // strobe write waiting one cycle
	logic [`ZOL_WORD_W-1:0] freq_ff; // working frequency
	logic [15:0] rdata_ff; // read answer
	logic sync_s1_ff; // sync line, first stage only
	logic sync_s2_ff; // sync line, usable
	logic sync_s3_ff; // previous usable sample
	logic [`ZOL_WORD_W-1:0] phase_w; // working phase
	logic fire; // a transfer happens this cycle
	logic init; // stage initializes this cycle
	logic wr_ctl; // control byte write
	logic ph_load; // phase load toward the nco
	logic [`ZOL_WORD_W-1:0] nxt_phase;
	logic [`ZOL_WORD_W-1:0] nxt_freq;
	zol_xfer_t xf; // decoded select
	zol_sel_t sel;

	// ***********************************************************
	// helpers
	// ***********************************************************

	// decode the select field into halves and direction
	// all sixteen codes are legal, so the case needs no default
	function automatic zol_xfer_t decode(input zol_sel_t s);
		zol_xfer_t d;
		d = '0;
		unique case (s)
			ZOL_NOP: d = '0;
			ZOL_ST_BOTH_BOTH: d = 7'b1111000;
			ZOL_RC_C_FRQ: d = 7'b0000100;
			ZOL_RC_C_PH: d = 7'b0000101;
			ZOL_RC_F_FRQ: d = 7'b0000010;
			ZOL_RC_F_PH: d = 7'b0000011;
			ZOL_RC_CF_FRQ: d = 7'b0000110;
			ZOL_RC_CF_PH: d = 7'b0000111;
			ZOL_ST_C_BOTH: d = 7'b1011000;
			ZOL_ST_F_BOTH: d = 7'b0111000;
			ZOL_ST_C_FRQ: d = 7'b1010000;
			ZOL_ST_C_PH: d = 7'b1001000;
			ZOL_ST_F_FRQ: d = 7'b0110000;
			ZOL_ST_F_PH: d = 7'b0101000;
			ZOL_ST_CF_FRQ: d = 7'b1110000;
			ZOL_ST_CF_PH: d = 7'b1101000;
		endcase
		decode = d;
	endfunction : decode

	// replace the coarse and/or fine half of a working word
	// coarse fills the top eleven bits, fine the low twenty-nine
	function automatic logic [`ZOL_WORD_W-1:0] merge(
		input logic [`ZOL_WORD_W-1:0] w,
		input logic [`ZOL_COARSE_W-1:0] c,
		input logic [`ZOL_FINE_W-1:0] f,
		input logic use_c,
		input logic use_f);
		logic [`ZOL_WORD_W-1:0] r;
		r = w;
		if (use_c) begin
			r[`ZOL_WORD_W-1:`ZOL_FINE_W] = c;
		end
		if (use_f) begin
			r[`ZOL_FINE_W-1:0] = f;
		end
		merge = r;
	endfunction : merge

	// ***********************************************************
	// trigger sources
	// ***********************************************************

	// sync pin arrives from outside: two stages before any use
	// the third stage only remembers the last synchronised level, so the
	// edge is taken between two clean samples; reset high avoids a false
	// fall when the pin idles high after reset
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sync_s1_ff <= 1'b1;
			sync_s2_ff <= 1'b1;
			sync_s3_ff <= 1'b1;
		end else begin
			sync_s1_ff <= trigger_sync_line;
			sync_s2_ff <= sync_s1_ff;
			sync_s3_ff <= sync_s2_ff;
		end
	end

	// falling sync edge with reset bit set initializes the stage
	assign init = ctl_ff[`ZOL_CTL_RESET] & sync_s3_ff & ~sync_s2_ff;

	// a strobe waits one cycle in strobe_ff; a trigger landing on that
	// cycle is folded into the same copy rather than run twice
	// strobe waiting and armed trigger merge into one transfer
	assign fire = strobe_ff | (armed & trig_event);
	assign wr_ctl = reg_wr & (reg_addr == `ZOL_OFS_CONTROL);

	// strobe write: data ignored, copy one cycle later
	// the data bus is not looked at: any write to the strobe address counts
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= reg_wr & (reg_addr == `ZOL_OFS_LOAD_STROBE);
		end
	end

	// ***********************************************************
	// control byte
	// ***********************************************************

	// write-only; clear bit drops itself when a transfer fires
	// init outranks a bus write so a sync fall always leaves a clean byte
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl_ff <= `ZOL_CTL_RESET_VAL;
		end else if (init) begin
			ctl_ff <= `ZOL_CTL_RESET_VAL;
		end else if (wr_ctl) begin
			// a fresh write wins over the self-clear in the same cycle
			ctl_ff <= reg_wdata[7:0];
		end else if (fire) begin
			ctl_ff[`ZOL_CTL_FILT_CLR] <= 1'b0;
		end
	end

	assign sel = zol_sel_t'(ctl_ff[`ZOL_CTL_SEL_MSB:`ZOL_CTL_SEL_LSB]);
	assign xf = decode(sel);

	// ***********************************************************
	// staging registers
	// ***********************************************************

	// bus writes and recall copies; the copy wins on a collision
	// limitation: software must not write staging while a recall is due,
	// the bus write of that cycle is dropped
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			coarse_ff <= '0;
			fine_ff <= '0;
		end else if (fire && (xf.rc_c || xf.rc_f)) begin
			if (xf.rc_c) begin
				coarse_ff <= xf.from_ph ? phase_w[`ZOL_WORD_W-1:`ZOL_FINE_W]
					: freq_ff[`ZOL_WORD_W-1:`ZOL_FINE_W];
			end
			if (xf.rc_f) begin
				fine_ff <= xf.from_ph ? phase_w[`ZOL_FINE_W-1:0]
					: freq_ff[`ZOL_FINE_W-1:0];
			end
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ZOL_OFS_COARSE_HIGH: coarse_ff[10:3] <= reg_wdata[7:0];
				`ZOL_OFS_COARSE_LOW: coarse_ff[2:0] <= reg_wdata[7:5];
				`ZOL_OFS_FINE_BYTE3: fine_ff[28:21] <= reg_wdata[7:0];
				`ZOL_OFS_FINE_BYTE2: fine_ff[20:13] <= reg_wdata[7:0];
				`ZOL_OFS_FINE_BYTE1: fine_ff[12:5] <= reg_wdata[7:0];
				`ZOL_OFS_FINE_BYTE0: fine_ff[4:0] <= reg_wdata[7:3];
				default: ; // other addresses leave staging alone
			endcase
		end
	end

	// ***********************************************************
	// working registers
	// ***********************************************************

	// a phase load is taken only on init or for store codes aimed at phase; recall
	// codes read the working words and leave them untouched
	// store copies build the next working words
	always_comb begin
		nxt_freq = merge(freq_ff, coarse_ff, fine_ff, xf.st_c, xf.st_f);
		nxt_phase = merge(phase_w, coarse_ff, fine_ff, xf.st_c, xf.st_f);
		ph_load = init | (fire & xf.to_ph & (xf.st_c | xf.st_f));
		if (init) begin
			nxt_phase = `ZOL_INIT_PHASE;
		end
	end

	// frequency: zeroed by init, replaced by a store
	// init wins over a store fired in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			freq_ff <= `ZOL_FREQ_RESET_VAL;
		end else if (init) begin
			freq_ff <= `ZOL_FREQ_RESET_VAL;
		end else if (fire && xf.to_frq) begin
			freq_ff <= nxt_freq;
		end
	end

	// phase lives in the accumulator so loads and steps never fight
	// sample_en steps the accumulator once per mixer sample
	zol_nco u_nco (
		.clock(clock),
		.rst(rst),
		.sample_en(mix_valid),
		.freq(freq_ff),
		.load(ph_load),
		.load_val(nxt_phase),
		.phase(phase_w)
	);

	assign osc_phase = phase_w;
	assign osc_freq = freq_ff;

	// ***********************************************************
	// lowpass
	// ***********************************************************

	// clear on a transfer with the clear bit, or on init
	// the filter bit is read live, so a bypass change acts on the next sample
	zol_lpf u_lpf (
		.clock(clock),
		.rst(rst),
		.enable(ctl_ff[`ZOL_CTL_FILT_EN]),
		.clear(init | (fire & ctl_ff[`ZOL_CTL_FILT_CLR])),
		.in_valid(mix_valid),
		.in_i(mix_i),
		.in_q(mix_q),
		.out_valid(zoom_valid),
		.out_i(zoom_i),
		.out_q(zoom_q)
	);

	// ***********************************************************
	// read path
	// ***********************************************************

	// one cycle read latency; upper byte and gaps read zero
	// the read answer is registered so reg_rdata comes from a flip-flop
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_ff <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`ZOL_OFS_COARSE_HIGH: rdata_ff <= {8'h00, coarse_ff[10:3]};
				`ZOL_OFS_COARSE_LOW: rdata_ff <= {8'h00, coarse_ff[2:0], 5'h0};
				`ZOL_OFS_FINE_BYTE3: rdata_ff <= {8'h00, fine_ff[28:21]};
				`ZOL_OFS_FINE_BYTE2: rdata_ff <= {8'h00, fine_ff[20:13]};
				`ZOL_OFS_FINE_BYTE1: rdata_ff <= {8'h00, fine_ff[12:5]};
				`ZOL_OFS_FINE_BYTE0: rdata_ff <= {8'h00, fine_ff[4:0], 3'h0};
				// write-only and unmapped addresses answer zero
				default: rdata_ff <= 16'h0000;
			endcase
		end
	end

	assign reg_rdata = rdata_ff;

endmodule : zol_loader

/* verilog/zol_lpf.sv */
// half-band lowpass on the complex mixer output, with bypass and clear
`timescale 1ns/1ps
`include "zol_consts.svh"

module zol_lpf (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// control
	input wire logic enable,
	input wire logic clear,
	// complex input
	input wire logic in_valid,
	input wire logic signed [`ZOL_SAMP_W-1:0] in_i,
	input wire logic signed [`ZOL_SAMP_W-1:0] in_q,
	// complex output
	output logic out_valid,
	output logic signed [`ZOL_SAMP_W-1:0] out_i,
	output logic signed [`ZOL_SAMP_W-1:0] out_q
);
	import zol_pkg::*;

	// ***********************************************************
	// filter state
	// ***********************************************************

	logic signed [`ZOL_SAMP_W-1:0] i1_ff; // i delay line
	logic signed [`ZOL_SAMP_W-1:0] i2_ff;
	logic signed [`ZOL_SAMP_W-1:0] q1_ff; // q delay line
	logic signed [`ZOL_SAMP_W-1:0] q2_ff;
	logic signed [`ZOL_SAMP_W-1:0] oi_ff;
	logic signed [`ZOL_SAMP_W-1:0] oq_ff;
	logic ov_ff;

	// 1-2-1 taps: null at half the rate, cheap stand-in for a half band
	function automatic logic signed [`ZOL_SAMP_W-1:0] tap3(
		input logic signed [`ZOL_SAMP_W-1:0] a,
		input logic signed [`ZOL_SAMP_W-1:0] b,
		input logic signed [`ZOL_SAMP_W-1:0] c);
		logic signed [`ZOL_SAMP_W+1:0] s;
		s = {{2{a[`ZOL_SAMP_W-1]}}, a} + {b[`ZOL_SAMP_W-1], b, 1'b0}
			+ {{2{c[`ZOL_SAMP_W-1]}}, c};
		tap3 = s[`ZOL_SAMP_W+1:2];
	endfunction : tap3

	// delay line, zeroed by clear
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			i1_ff <= '0;
			i2_ff <= '0;
			q1_ff <= '0;
			q2_ff <= '0;
		end else if (clear) begin
			i1_ff <= '0;
			i2_ff <= '0;
			q1_ff <= '0;
			q2_ff <= '0;
		end else if (in_valid) begin
			i1_ff <= in_i;
			i2_ff <= i1_ff;
			q1_ff <= in_q;
			q2_ff <= q1_ff;
		end
	end

	// output: filtered when enabled, straight through otherwise
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			oi_ff <= '0;
			oq_ff <= '0;
			ov_ff <= 1'b0;
		end else begin
			ov_ff <= in_valid;
			if (in_valid) begin
				if (enable) begin
					oi_ff <= tap3(in_i, i1_ff, i2_ff);
					oq_ff <= tap3(in_q, q1_ff, q2_ff);
				end else begin
					oi_ff <= in_i;
					oq_ff <= in_q;
				end
			end
		end
	end

	assign out_i = oi_ff;
	assign out_q = oq_ff;
	assign out_valid = ov_ff;

endmodule : zol_lpf

/* verilog/zol_nco.sv */
// phase accumulator of the zoom oscillator with a direct load port
`timescale 1ns/1ps
`include "zol_consts.svh"

module zol_nco (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// sample pacing and step
	input wire logic sample_en,
	input wire logic [`ZOL_WORD_W-1:0] freq,
	// load of a new phase value
	input wire logic load,
	input wire logic [`ZOL_WORD_W-1:0] load_val,
	// accumulated phase
	output logic [`ZOL_WORD_W-1:0] phase
);
	import zol_pkg::*;

	// ***********************************************************
	// accumulator
	// ***********************************************************

	logic [`ZOL_WORD_W-1:0] phase_ff; // working phase

	// a load wins over the step so a new phase lands exactly
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_ff <= `ZOL_INIT_PHASE;
		end else if (load) begin
			phase_ff <= load_val;
		end else if (sample_en) begin
			phase_ff <= phase_ff + freq;
		end
	end

	assign phase = phase_ff;

endmodule : zol_nco

/* verilog/zol_pkg.sv */
// types shared by the zoom oscillator loader modules
package zol_pkg;

	// transfer codes held in the control byte
	typedef enum logic [3:0] {
		ZOL_NOP = 4'h0,
		ZOL_ST_BOTH_BOTH = 4'h1,
		ZOL_RC_C_FRQ = 4'h2,
		ZOL_RC_C_PH = 4'h3,
		ZOL_RC_F_FRQ = 4'h4,
		ZOL_RC_F_PH = 4'h5,
		ZOL_RC_CF_FRQ = 4'h6,
		ZOL_RC_CF_PH = 4'h7,
		ZOL_ST_C_BOTH = 4'h8,
		ZOL_ST_F_BOTH = 4'h9,
		ZOL_ST_C_FRQ = 4'ha,
		ZOL_ST_C_PH = 4'hb,
		ZOL_ST_F_FRQ = 4'hc,
		ZOL_ST_F_PH = 4'hd,
		ZOL_ST_CF_FRQ = 4'he,
		ZOL_ST_CF_PH = 4'hf
	} zol_sel_t;

	// decoded transfer: which halves move and in which direction
	typedef struct packed {
		logic st_c;
		logic st_f;
		logic to_frq;
		logic to_ph;
		logic rc_c;
		logic rc_f;
		logic from_ph;
	} zol_xfer_t;

endpackage : zol_pkg
